// ### design/mii_port_with_straps.sv
// Function
// - Transmit data leaves as 4-bit nibbles changing with the transmit clock at 10 and 100 Mbps.
// - The I/O base address is the three low transmit data strap bits times 0x10 plus 0x300.
// - Interrupt request is active low when the management clock strap is high, else active high.
// - Carrier sense is high during receive or transmit activity and is driven by us in reverse mode.
// - Collision is driven by us in reverse mode and taken as an input in normal mode.
// - We drive the management clock and run management data bidirectionally.
`default_nettype none
`include "mii_port_defs.svh"
module mii_port_with_straps (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hw_reset,
    input wire logic reverse_mode,
    input wire logic tx_clk,
    input wire logic rx_clk,
    input wire logic [3:0] rxd,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic link_in,
    input wire logic [3:0] txd_in,
    output logic [3:0] txd,
    output logic [3:0] txd_oe,
    output logic tx_en,
    input wire logic crs_in,
    output logic crs_out,
    output logic crs_oe,
    input wire logic col_in,
    output logic col_out,
    output logic col_oe,
    input wire logic mdc_in,
    output logic mdc,
    output logic mdc_oe,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic [5:0] host_addr_high_lines,
    input wire logic host_addr_qualifier,
    output logic host_select,
    output logic [9:0] io_base,
    input wire logic irq_event,
    output logic irq_out,
    input wire logic [3:0] tx_nibble,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [3:0] rx_nibble,
    output logic rx_valid,
    output logic rx_error,
    output logic crs_status,
    output logic col_status,
    output logic link_status,
    input wire logic mgmt_start,
    input wire logic [31:0] mgmt_frame,
    output logic mgmt_busy,
    output logic [15:0] mgmt_rdata
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
    logic [16:0] sync_q;
    logic tx_clk_s, rx_clk_s, rx_dv_s, rx_er_s, link_s, crs_s, col_s, mdio_s, hw_reset_s;
    logic [3:0] rxd_s;
    logic [2:0] strap_s;
    logic mdc_strap_s;

    sync2 #(.WIDTH(17)) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .d({tx_clk, rx_clk, rxd, rx_dv, rx_er, link_in, crs_in, col_in, mdio_in, hw_reset,
            txd_in[2:0], mdc_in}),
        .q(sync_q)
    );
    assign {tx_clk_s, rx_clk_s, rxd_s, rx_dv_s, rx_er_s, link_s, crs_s, col_s, mdio_s, hw_reset_s,
            strap_s, mdc_strap_s} = sync_q;

////////////////////////////////////////////////////////////////////////////////
// Straps
    logic [2:0] strap_base_r;
    logic strap_irq_low_r;
    logic [3:0] settle_r;

    // Straps track the pins while reset is held and for three cycles after release, then freeze
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            settle_r <= `STRAP_SETTLE_CYCLES;
            strap_base_r <= 3'h0;
            strap_irq_low_r <= 1'b0;
        end else if (hw_reset_s || settle_r != 4'h0) begin
            if (!hw_reset_s)
                settle_r <= settle_r - 4'h1;
            else
                settle_r <= `STRAP_SETTLE_CYCLES;
            strap_base_r <= strap_s;
            strap_irq_low_r <= mdc_strap_s;
        end
    end

    logic straps_held;
    assign straps_held = !hw_reset_s && settle_r == 4'h0;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            io_base <= 10'h000;
            irq_out <= 1'b0;
            host_select <= 1'b0;
        end else begin
            io_base <= `IO_BASE_OFFSET + {3'h0, strap_base_r, 4'h0};
            irq_out <= irq_event ^ strap_irq_low_r;
            host_select <= host_addr_high_lines[5] && host_addr_high_lines[4] && !host_addr_high_lines[3]
                && !host_addr_qualifier && host_addr_high_lines[2:0] == strap_base_r;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Transmit path
    logic tx_clk_d_r, rx_clk_d_r;
    logic tx_rise, rx_rise;
    assign tx_rise = tx_clk_s && !tx_clk_d_r;
    assign rx_rise = rx_clk_s && !rx_clk_d_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_clk_d_r <= 1'b0;
            rx_clk_d_r <= 1'b0;
        end else begin
            tx_clk_d_r <= tx_clk_s;
            rx_clk_d_r <= rx_clk_s;
        end
    end

    mii_port_pkg::tx_state_type tx_state_r;

    // Nibble launched on each transmit clock rise; pins released during strap window
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_state_r <= mii_port_pkg::TX_IDLE;
            txd <= 4'h0;
            tx_en <= 1'b0;
            tx_ready <= 1'b0;
            txd_oe <= 4'h0;
        end else begin
            txd_oe <= straps_held ? 4'hf : 4'h0;
            tx_ready <= 1'b0;
            if (tx_rise && straps_held) begin
                case (tx_state_r)
                    mii_port_pkg::TX_IDLE: begin
                        if (tx_valid) begin
                            txd <= tx_nibble;
                            tx_en <= 1'b1;
                            tx_ready <= 1'b1;
                            tx_state_r <= mii_port_pkg::TX_SEND;
                        end
                    end
                    mii_port_pkg::TX_SEND: begin
                        if (tx_valid) begin
                            txd <= tx_nibble;
                            tx_ready <= 1'b1;
                        end else begin
                            txd <= 4'h0;
                            tx_en <= 1'b0;
                            tx_state_r <= mii_port_pkg::TX_IDLE;
                        end
                    end
                    default: tx_state_r <= mii_port_pkg::TX_IDLE;
                endcase
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Receive path, carrier and collision
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_nibble <= 4'h0;
            rx_valid <= 1'b0;
            rx_error <= 1'b0;
        end else begin
            rx_valid <= rx_rise && rx_dv_s;
            if (rx_rise) begin
                rx_nibble <= rxd_s;
                rx_error <= rx_dv_s && rx_er_s;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            crs_out <= 1'b0;
            crs_oe <= 1'b0;
            col_out <= 1'b0;
            col_oe <= 1'b0;
            crs_status <= 1'b0;
            col_status <= 1'b0;
            link_status <= 1'b0;
        end else begin
            crs_oe <= reverse_mode;
            col_oe <= reverse_mode;
            crs_out <= rx_dv_s || tx_en;
            col_out <= rx_dv_s && tx_en;
            crs_status <= reverse_mode ? (rx_dv_s || tx_en) : crs_s;
            col_status <= reverse_mode ? (rx_dv_s && tx_en) : col_s;
            link_status <= link_s;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Management interface
    mii_port_pkg::mgmt_state_type mg_state_r;
    logic [7:0] mdc_div_r;
    logic [5:0] bit_cnt_r;
    logic [31:0] mg_shift_r;
    logic mg_read_r;

    // Rising edge of the management clock ends each half period of low
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mg_state_r <= mii_port_pkg::MG_IDLE;
            mdc_div_r <= 8'h00;
            bit_cnt_r <= 6'h00;
            mg_shift_r <= 32'h0;
            mg_read_r <= 1'b0;
            mdc <= 1'b0;
            mdc_oe <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
            mgmt_busy <= 1'b0;
            mgmt_rdata <= 16'h0;
        end else begin
            mdc_oe <= straps_held;
            case (mg_state_r)
                mii_port_pkg::MG_IDLE: begin
                    mdc <= 1'b0;
                    mdio_oe <= 1'b0;
                    if (mgmt_start && straps_held) begin
                        mg_shift_r <= mgmt_frame;
                        mg_read_r <= mgmt_frame[29:28] == 2'b10;
                        bit_cnt_r <= 6'h00;
                        mdc_div_r <= 8'h00;
                        mgmt_busy <= 1'b1;
                        mdio_oe <= 1'b1;
                        mdio_out <= mgmt_frame[31];
                        mg_state_r <= mii_port_pkg::MG_SHIFT;
                    end
                end
                mii_port_pkg::MG_SHIFT: begin
                    if (mdc_div_r == `MDC_HALF_PERIOD - 8'h01) begin
                        mdc_div_r <= 8'h00;
                        mdc <= !mdc;
                        if (mdc) begin
                            mg_shift_r <= {mg_shift_r[30:0], mdio_s};
                            bit_cnt_r <= bit_cnt_r + 6'h01;
                            mdio_out <= mg_shift_r[30];
                            if (mg_read_r && bit_cnt_r == 6'd13)
                                mdio_oe <= 1'b0;
                            if (bit_cnt_r == 6'd31)
                                mg_state_r <= mii_port_pkg::MG_DONE;
                        end
                    end else begin
                        mdc_div_r <= mdc_div_r + 8'h01;
                    end
                end
                mii_port_pkg::MG_DONE: begin
                    mdio_oe <= 1'b0;
                    mgmt_busy <= 1'b0;
                    if (mg_read_r)
                        mgmt_rdata <= mg_shift_r[15:0];
                    mg_state_r <= mii_port_pkg::MG_IDLE;
                end
                default: mg_state_r <= mii_port_pkg::MG_IDLE;
            endcase
        end
    end
endmodule : mii_port_with_straps
`default_nettype wire

// ### design/mii_port_defs.svh
`ifndef MII_PORT_DEFS_SVH
`define MII_PORT_DEFS_SVH
// I/O base from strap
`define IO_BASE_OFFSET 10'h300
`define IO_BASE_STEP_SHIFT 4
`define STRAP_BITS 3
// Management clock divider
`define MDC_HALF_PERIOD 8'h04
// Release delay before straps are final
`define STRAP_SETTLE_CYCLES 4'h3
`endif

// ### design/mii_port_pkg.sv
`default_nettype none
package mii_port_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01
    } tx_state_type;
    typedef enum logic [1:0] {
        MG_IDLE = 2'b00,
        MG_SHIFT = 2'b01,
        MG_DONE = 2'b10
    } mgmt_state_type;
endpackage : mii_port_pkg
`default_nettype wire

// ### design/sync2.sv
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sync2
`default_nettype wire

// ### sim/mii_phy_model.sv
`default_nettype none
module mii_phy_model (
    input wire logic tx_run,
    input wire logic tx_en,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    output logic tx_clk,
    output logic rx_clk,
    output logic [3:0] rxd,
    output logic rx_dv,
    output logic phy_crs,
    output logic mdio_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        tx_clk = 1'b0;
        rx_clk = 1'b0;
        rxd = 4'h0;
        rx_dv = 1'b0;
    end
    // Clock stands still outside frames
    always #400 if (tx_run) tx_clk = ~tx_clk;
    assign phy_crs = rx_dv | tx_en;
    // Answers ones while the device listens
    assign mdio_in = mdio_oe ? mdio_out : 1'b1;
    task automatic rx_frame(input logic [15:0] d);
        for (int i = 0; i < 4; i++) begin
            rxd = d[4*i +: 4];
            rx_dv = 1'b1;
            #400 rx_clk = 1'b1;
            #400 rx_clk = 1'b0;
        end
        rxd = ~rxd;
        rx_dv = 1'b0;
    endtask : rx_frame
endmodule : mii_phy_model
`default_nettype wire

// ### sim/mii_port_with_straps_checker.sv
`default_nettype none
module mii_port_with_straps_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic hw_reset,
    input wire logic reverse_mode,
    input wire logic rx_dv,
    input wire logic [3:0] txd_in,
    input wire logic [3:0] txd,
    input wire logic tx_en,
    input wire logic tx_ready,
    input wire logic [3:0] tx_nibble,
    input wire logic crs_out,
    input wire logic crs_oe,
    input wire logic col_out,
    input wire logic col_oe,
    input wire logic mdc_in,
    input wire logic mdc,
    input wire logic mdc_oe,
    input wire logic mdio_oe,
    input wire logic [5:0] host_addr_high_lines,
    input wire logic host_addr_qualifier,
    input wire logic host_select,
    input wire logic [9:0] io_base,
    input wire logic irq_event,
    input wire logic irq_out,
    input wire logic mgmt_busy
);
    logic strap_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge mclk) if (hw_reset) strap_r <= mdc_in;
    a_base_strap: assert property ((hw_reset && $stable(txd_in))[*8] |-> io_base == {3'b110, txd_in[2:0], 4'h0})
        else $error("io base differs from strap");
    a_base_held: assert property (!hw_reset[*8] |-> $stable(io_base))
        else $error("io base moved after reset");
    a_irq_polarity: assert property ((!hw_reset && $stable(irq_event))[*4] |-> irq_out == (irq_event ^ strap_r))
        else $error("irq polarity wrong");
    a_select_match: assert property (!hw_reset[*8] |=> host_select == (!$past(host_addr_qualifier)
        && $past(host_addr_high_lines) == {3'b110, $past(io_base[6:4])}))
        else $error("host select wrong");
    a_tx_nibble: assert property (tx_ready |-> tx_en && txd == $past(tx_nibble) ##1 !tx_ready)
        else $error("transmit nibble wrong");
    a_txd_steady: assert property ($changed(txd) |-> tx_ready || !tx_en)
        else $error("txd changed between clocks");
    a_rev_enables: assert property ($stable(reverse_mode)[*2] |-> crs_oe == reverse_mode && col_oe == reverse_mode)
        else $error("crs col enables wrong");
    a_rev_carrier: assert property ((reverse_mode && rx_dv)[*4] |-> crs_out && !col_out)
        else $error("reverse carrier wrong");
    a_mgmt_drive: assert property ($rose(mgmt_busy) |-> mdc_oe && mdio_oe)
        else $error("management lines not driven");
    a_mdc_period: assert property ($rose(mdc) |-> mdc[*4] ##1 !mdc)
        else $error("mdc period wrong");
    c_tx: cover property (tx_ready);
    c_mgmt: cover property ($fell(mgmt_busy));
    c_sel: cover property (host_select);
endmodule : mii_port_with_straps_checker
bind mii_port_with_straps mii_port_with_straps_checker chk (.mclk, .nrst, .hw_reset, .reverse_mode, .rx_dv,
    .txd_in, .txd, .tx_en, .tx_ready, .tx_nibble, .crs_out, .crs_oe, .col_out, .col_oe, .mdc_in, .mdc, .mdc_oe,
    .mdio_oe, .host_addr_high_lines, .host_addr_qualifier, .host_select, .io_base, .irq_event, .irq_out, .mgmt_busy);
`default_nettype wire

// ### sim/mii_port_with_straps_tb.sv
`default_nettype none
module mii_port_with_straps_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, nrst, hw_reset, reverse_mode, tx_run, link_in, irq_event, tx_valid, mgmt_start, host_addr_qualifier;
    logic mdc_strap, tx_clk, rx_clk, rx_dv, phy_crs, mdio_in, tx_ready, rx_valid, rx_error, mgmt_busy, host_select;
    logic irq_out, tx_en, crs_out, crs_oe, col_out, col_oe, mdc, mdc_oe, mdio_out, mdio_oe, crs_in, col_in, mdc_in;
    logic crs_status, col_status, link_status;
    logic [2:0] txd_strap;
    logic [3:0] tx_nibble, rxd, txd, txd_oe, rx_nibble, txd_in;
    logic [5:0] host_addr_high_lines;
    logic [9:0] io_base;
    logic [15:0] mgmt_rdata;
    logic [31:0] mgmt_frame;
    int miscompares, n_tests;
    // Pin levels: pull resistors give the straps
    assign txd_in = (txd & txd_oe) | ({1'b0, txd_strap} & ~txd_oe);
    assign mdc_in = mdc_oe ? mdc : mdc_strap;
    assign crs_in = crs_oe ? crs_out : phy_crs;
    assign col_in = col_oe ? col_out : 1'b0;
    mii_port_with_straps DUT (.mclk, .nrst, .hw_reset, .reverse_mode, .tx_clk, .rx_clk, .rxd, .rx_dv, .rx_er(1'b0),
        .link_in, .txd_in, .txd, .txd_oe, .tx_en, .crs_in, .crs_out, .crs_oe, .col_in, .col_out, .col_oe, .mdc_in,
        .mdc, .mdc_oe, .mdio_in, .mdio_out, .mdio_oe, .host_addr_high_lines, .host_addr_qualifier, .host_select,
        .io_base, .irq_event, .irq_out, .tx_nibble, .tx_valid, .tx_ready, .rx_nibble, .rx_valid, .rx_error,
        .crs_status, .col_status, .link_status, .mgmt_start, .mgmt_frame, .mgmt_busy, .mgmt_rdata);
    mii_phy_model phy (.tx_run, .tx_en, .mdio_out, .mdio_oe, .tx_clk, .rx_clk, .rxd, .rx_dv, .phy_crs, .mdio_in);
    always #50 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic t_straps;
        for (int s = 0; s < 8; s++) begin
            @(negedge mclk) hw_reset = 1'b1;
            txd_strap = 3'(s);
            mdc_strap = s[0];
            repeat (14) @(negedge mclk);
            hw_reset = 1'b0;
            repeat (10) @(negedge mclk);
            txd_strap = ~txd_strap;
            mdc_strap = ~mdc_strap;
            irq_event = 1'b1;
            host_addr_high_lines = {3'b110, 3'(s)};
            repeat (4) @(negedge mclk);
            check(io_base, 10'h300 + 10'(s) * 10'h10);
            check(irq_out, 1'b1 ^ s[0]);
            check(host_select, 1'b1);
            irq_event = 1'b0;
            host_addr_qualifier = 1'b1;
            repeat (4) @(negedge mclk);
            check({irq_out, host_select}, {s[0], 1'b0});
            host_addr_qualifier = 1'b0;
        end
        $display("strap test end");
    endtask : t_straps
    task automatic t_tx;
        tx_run = 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(negedge mclk) tx_nibble = 4'h9 + 4'(i * 3);
            tx_valid = 1'b1;
            @(posedge mclk) #1;
            for (int k = 0; k < 20 && tx_ready !== 1'b1; k++) @(posedge mclk) #1;
            check({tx_ready, tx_en, txd}, {2'b11, tx_nibble});
        end
        check({crs_status, col_status, link_status, txd_oe}, 7'h5f);
        @(negedge mclk) tx_valid = 1'b0;
        repeat (20) @(negedge mclk);
        check(tx_en, 1'b0);
        tx_run = 1'b0;
        $display("transmit test end");
    endtask : t_tx
    task automatic t_rx_reverse;
        logic [3:0] got[$];
        reverse_mode = 1'b1;
        repeat (4) @(negedge mclk);
        check({crs_oe, col_oe, crs_out}, 3'b110);
        fork
            phy.rx_frame(16'ha5c3);
            repeat (40) begin
                @(posedge mclk) #1;
                if (rx_valid === 1'b1) got.push_back(rx_nibble);
            end
            begin
                repeat (8) @(negedge mclk);
                check({crs_out, col_out, crs_status, col_status, rx_error}, 5'b10100);
            end
        join
        check({got[3], got[2], got[1], got[0]}, 16'ha5c3);
        reverse_mode = 1'b0;
        repeat (4) @(negedge mclk);
        check({crs_oe, col_oe}, 2'b00);
        $display("receive test end");
    endtask : t_rx_reverse
    task automatic t_mgmt;
        @(negedge mclk) mgmt_frame = 32'h6002_0000;
        mgmt_start = 1'b1;
        @(negedge mclk) mgmt_start = 1'b0;
        check({mgmt_busy, mdc_oe, mdio_oe, mdio_out}, 4'he);
        for (int k = 0; k < 400 && mgmt_busy !== 1'b0; k++) @(negedge mclk);
        check({mgmt_busy, mgmt_rdata}, 17'h0ffff);
        $display("management test end");
    endtask : t_mgmt
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial begin
        {mclk, nrst, hw_reset, reverse_mode, tx_run, link_in, irq_event, tx_valid, mgmt_start} = 9'h004;
        {host_addr_qualifier, mdc_strap, txd_strap, tx_nibble, host_addr_high_lines, mgmt_frame} = '0;
        repeat (2) @(negedge mclk);
        nrst = 1'b1;
        link_in = 1'b1;
        t_straps();
        t_tx();
        t_rx_reverse();
        t_mgmt();
        complete_run();
    end
    initial begin
        #500000;
        miscompares++;
        complete_run();
    end
endmodule : mii_port_with_straps_tb
`default_nettype wire
